// ---- lic_pkg.sv ----
// Package for the legacy interrupt cause and mask block.
// Assumes a single 125 MHz clock domain and a plain register port.
package lic_pkg;

    localparam logic [15:0] LIC_CAUSE_OFF = 16'h1500;
    localparam logic [15:0] LIC_SET_OFF = 16'h1504;
    localparam logic [15:0] LIC_MASK_OFF = 16'h1508;
    localparam logic [15:0] LIC_MCLR_OFF = 16'h150C;
    localparam logic [15:0] LIC_AUTO_OFF = 16'h1510;
    localparam logic [15:0] LIC_CFG_OFF = 16'h1514;

    // Cause bit positions
    localparam int LIC_TX_DESCRIPTOR_WRITEBACK_CAUSE = 0;
    localparam int LIC_LSC = 2;
    localparam int LIC_RXLOW = 4;
    localparam int LIC_RXMISS = 6;
    localparam int LIC_RX_DESCRIPTOR_WRITEBACK_CAUSE = 7;
    localparam int LIC_PHY = 10;
    localparam int LIC_PIN0 = 11;
    localparam int LIC_TSYNC = 19;
    localparam int LIC_FER = 22;
    localparam int LIC_BUSX = 24;
    localparam int LIC_SCE = 25;
    localparam int LIC_WDOG = 26;
    localparam int LIC_TCPT = 29;
    localparam int LIC_DRST = 30;
    localparam int LIC_LINE = 31;

    // Implemented cause bits, 31 is the live line flag
    localparam logic [31:0] LIC_IMPL = 32'h67487CD5;
    localparam logic [31:0] LIC_AUTO_IMPL = 32'h7FFFFFFF;
    localparam logic [31:0] LIC_ZERO = 32'h00000000;
    localparam logic [1:0] LIC_CFG_RST = 2'h0;
    localparam int LIC_CFG_NOCOR = 0;
    localparam int LIC_CFG_NSQ = 1;

    typedef struct packed {
        logic tx_wb;
        logic rx_wb;
        logic link_up;
        logic rx_low;
        logic rx_overrun;
        logic phy_irq;
        logic tsync_irq;
        logic mem_fatal;
        logic [4:0] bus_exc;
        logic sce_active;
        logic wdog_expire;
        logic tcp_terminal;
    } lic_events_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lic_req_t;

endpackage

// ---- lic_top.sv ----
// Legacy interrupt cause, cause-set and mask logic with summary and line out.
// Assumes events are one-cycle pulses or levels in the clock domain; the
// four general purpose pins are asynchronous and resynchronised here.
// Contract
// - Each event sets its cause bit, held until cleared.
// - Summary other bit is OR of cause bits ANDed with mask, clears when none.
// - Reading cause clears it unless the config bit disables that.
// - Writing one to cause at 0x1500 clears that bit.
// - No automatic clear of cause bits exists.
// - Bit 0 on tx descriptor writeback, bit 7 on rx writeback.
// - Bit 2 on any link status change, either direction.
// - Bit 4 when receive descriptors reach the low threshold.
// - Overrun drops packet, counts missed packet, sets bit 6.
// - Enabled pins 0-3 sampled high set bits 11 to 14.
// - Bit 19 on time sync interrupt, bit 10 on phy interrupt.
// - Bit 22 on fatal internal memory error.
// - Bit 24 on enabled logged bus exception.
// - Bit 25 when coalescing clock control toggles.
// - Bit 26 on watchdog expiry, bit 29 on transport timer.
// - Bit 30 on device reset, kept through device reset.
// - Bit 31 reads as the live legacy line state.
// - Cause-set at 0x1504 sets bits written one.
// - Setting bit 30 by cause-set raises reset interrupt here only.
// - Mask at 0x1508 reads back; writing one sets mask bits.
// - Host interrupt whenever a set cause has its mask set.
// - Mask bit 30 survives device reset.
// - Mask-clear at 0x150C clears bits written one, reads mask.
// - Cause access copies auto-mask into mask-clear, qualified.
`timescale 1ns/1ps
`default_nettype none
module lic_top
    import lic_pkg::*;
#(
    parameter int MISS_W = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic device_soft_reset,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Event sources
    input wire lic_events_t events,
    input wire logic [4:0] bus_exception_enable,
    input wire logic [3:0] pin_in,
    input wire logic [3:0] pin_detect_enable,
    // Results
    output logic irq_line,
    output logic extended_summary_other_bit,
    output logic [MISS_W-1:0] missed_packet_counter
);

    logic rst_a;
    logic rst_n;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic link_prev;
    logic sce_prev;
    logic soft_prev;
    logic [31:0] cause;
    logic [31:0] mask;
    logic [30:0] auto_mask;
    logic [1:0] cfg;
    logic [31:0] hw_set;
    logic [31:0] next_cause;
    logic [31:0] next_mask;
    logic [31:0] pending;
    logic line;
    logic soft_rise;
    lic_req_t req;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Reset release through two flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    // Pin synchroniser; second stage only is read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            link_prev <= 1'b0;
            sce_prev <= 1'b0;
            soft_prev <= 1'b0;
        end else begin
            link_prev <= events.link_up;
            sce_prev <= events.sce_active;
            soft_prev <= device_soft_reset;
        end
    end

    assign soft_rise = device_soft_reset && !soft_prev;

    // Hardware set sources
    always_comb begin
        hw_set = LIC_ZERO;
        hw_set[LIC_TX_DESCRIPTOR_WRITEBACK_CAUSE] = events.tx_wb;
        hw_set[LIC_RX_DESCRIPTOR_WRITEBACK_CAUSE] = events.rx_wb;
        hw_set[LIC_LSC] = events.link_up ^ link_prev;
        hw_set[LIC_RXLOW] = events.rx_low;
        hw_set[LIC_RXMISS] = events.rx_overrun;
        hw_set[LIC_PHY] = events.phy_irq;
        hw_set[LIC_TSYNC] = events.tsync_irq;
        hw_set[LIC_FER] = events.mem_fatal;
        hw_set[LIC_BUSX] = |(events.bus_exc & bus_exception_enable);
        hw_set[LIC_SCE] = events.sce_active ^ sce_prev;
        hw_set[LIC_WDOG] = events.wdog_expire;
        hw_set[LIC_TCPT] = events.tcp_terminal;
        hw_set[LIC_DRST] = soft_rise;
    end

    logic [3:0] hw_set_pin;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            assign hw_set_pin[gi] = pin_s2[gi] && pin_detect_enable[gi];
        end
    endgenerate

    logic cause_access;
    logic cause_rd;
    logic cause_wr;
    logic set_wr;
    logic mask_wr;
    logic mclr_wr;
    logic auto_go;
    logic [31:0] clr;
    logic [31:0] set_all;

    assign cause_rd = req.rd && req.addr == LIC_CAUSE_OFF;
    assign cause_wr = req.wr && req.addr == LIC_CAUSE_OFF;
    assign set_wr = req.wr && req.addr == LIC_SET_OFF;
    assign mask_wr = req.wr && req.addr == LIC_MASK_OFF;
    assign mclr_wr = req.wr && req.addr == LIC_MCLR_OFF;
    assign cause_access = cause_rd || cause_wr;
    assign auto_go = cause_access && (cfg[LIC_CFG_NSQ] || ((|mask) && line));

    always_comb begin
        clr = LIC_ZERO;
        if (cause_rd && !cfg[LIC_CFG_NOCOR]) begin
            clr = LIC_IMPL;
        end
        if (cause_wr) begin
            clr = clr | req.wdata;
        end
        set_all = hw_set | {17'h0, hw_set_pin, 11'h0};
        if (set_wr) begin
            set_all = set_all | req.wdata;
        end
        // Set wins over clear; no other clearing path exists
        next_cause = ((cause & ~clr) | set_all) & LIC_IMPL;
        next_mask = mask;
        if (mask_wr) begin
            next_mask = next_mask | req.wdata;
        end
        if (mclr_wr) begin
            next_mask = next_mask & ~req.wdata;
        end
        if (auto_go) begin
            next_mask = next_mask & ~{1'b0, auto_mask};
        end
        next_mask = next_mask & LIC_IMPL;
        // Soft reset keeps only the reset-interrupt enable
        if (soft_rise) begin
            next_mask = next_mask & (32'h1 << LIC_DRST);
        end
    end

    // Cause bits survive device soft reset; of the two resets only resetn clears them
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cause <= LIC_ZERO;
        end else begin
            cause <= next_cause;
        end
    end

    // Soft reset folded into next_mask so the line output sees it as well
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask <= LIC_ZERO;
        end else begin
            mask <= next_mask;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            auto_mask <= 31'h0;
            cfg <= LIC_CFG_RST;
        end else begin
            if (soft_rise) begin
                auto_mask <= auto_mask & (31'h1 << LIC_DRST);
            end else if (req.wr && req.addr == LIC_AUTO_OFF) begin
                auto_mask <= req.wdata[30:0];
            end
            if (req.wr && req.addr == LIC_CFG_OFF) begin
                cfg <= req.wdata[1:0];
            end
        end
    end

    // Missed packet counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            missed_packet_counter <= '0;
        end else if (events.rx_overrun) begin
            missed_packet_counter <= missed_packet_counter + 1'b1;
        end
    end

    assign pending = cause & mask;
    assign line = |pending;

    // Registered line and summary outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_line <= 1'b0;
            extended_summary_other_bit <= 1'b0;
        end else begin
            irq_line <= |(next_cause & next_mask);
            extended_summary_other_bit <= |(next_cause & next_mask);
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= LIC_ZERO;
        end else if (req.rd) begin
            case (req.addr)
                LIC_CAUSE_OFF: reg_rdata <= {line, cause[30:0]};
                LIC_MASK_OFF: reg_rdata <= mask;
                LIC_MCLR_OFF: reg_rdata <= mask;
                LIC_AUTO_OFF: reg_rdata <= {1'b0, auto_mask};
                LIC_CFG_OFF: reg_rdata <= {30'h0, cfg};
                default: reg_rdata <= LIC_ZERO;
            endcase
        end else begin
            reg_rdata <= LIC_ZERO;
        end
    end

    // Assertions
    // Registered line and summary must track the stored cause and mask
    a_line_follows: assert property (@(posedge clock) disable iff (!rst_n)
        irq_line == line)
        else $error("line does not match cause and mask");
    a_summary_eq: assert property (@(posedge clock) disable iff (!rst_n)
        extended_summary_other_bit == line)
        else $error("summary differs from cause and mask");
    a_read_line: assert property (@(posedge clock) disable iff (!rst_n)
        cause_rd |=> reg_rdata[LIC_LINE] == $past(line))
        else $error("line flag not returned on cause read");
    // Event capture
    a_tx_set: assert property (@(posedge clock) disable iff (!rst_n)
        events.tx_wb |=> cause[LIC_TX_DESCRIPTOR_WRITEBACK_CAUSE])
        else $error("tx writeback not recorded");
    a_link_edge: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(events.link_up) |=> cause[LIC_LSC])
        else $error("link change not recorded");
    a_rx_miss: assert property (@(posedge clock) disable iff (!rst_n)
        events.rx_overrun |=> cause[LIC_RXMISS])
        else $error("overrun not recorded");
    a_miss_count: assert property (@(posedge clock) disable iff (!rst_n)
        events.rx_overrun |=> missed_packet_counter == $past(missed_packet_counter) + 1'b1)
        else $error("missed packet count not advanced");
    a_phy_set: assert property (@(posedge clock) disable iff (!rst_n)
        events.phy_irq |=> cause[LIC_PHY])
        else $error("phy interrupt not recorded");
    a_pin_set: assert property (@(posedge clock) disable iff (!rst_n)
        (pin_s2[0] && pin_detect_enable[0]) |=> cause[LIC_PIN0])
        else $error("pin input not recorded");
    a_bus_exc: assert property (@(posedge clock) disable iff (!rst_n)
        (|(events.bus_exc & bus_exception_enable)) |=> cause[LIC_BUSX])
        else $error("bus exception not recorded");
    a_sce_edge: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(events.sce_active) |=> cause[LIC_SCE])
        else $error("coalescing event not recorded");
    a_wdog_set: assert property (@(posedge clock) disable iff (!rst_n)
        events.wdog_expire |=> cause[LIC_WDOG])
        else $error("watchdog expiry not recorded");
    a_soft_cause: assert property (@(posedge clock) disable iff (!rst_n)
        soft_rise |=> cause[LIC_DRST])
        else $error("device reset not recorded");
    // Clear, hold and cause-set paths
    a_cause_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (cause[LIC_FER] && !cause_access) |=> cause[LIC_FER])
        else $error("cause bit dropped without access");
    a_w1c_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (cause_wr && req.wdata[LIC_WDOG] && !set_all[LIC_WDOG]) |=> !cause[LIC_WDOG])
        else $error("write one did not clear");
    a_cor_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (cause_rd && !cfg[LIC_CFG_NOCOR] && !set_all[LIC_TCPT]) |=> !cause[LIC_TCPT])
        else $error("read did not clear");
    a_cor_keep: assert property (@(posedge clock) disable iff (!rst_n)
        (cause_rd && cfg[LIC_CFG_NOCOR] && cause[LIC_RX_DESCRIPTOR_WRITEBACK_CAUSE]) |=> cause[LIC_RX_DESCRIPTOR_WRITEBACK_CAUSE])
        else $error("read cleared while disabled");
    a_set_reg: assert property (@(posedge clock) disable iff (!rst_n)
        (set_wr && req.wdata[LIC_DRST]) |=> cause[LIC_DRST])
        else $error("cause set ignored");
    // Mask paths
    a_mask_set: assert property (@(posedge clock) disable iff (!rst_n)
        (mask_wr && req.wdata[LIC_PHY] && !mclr_wr && !auto_go && !soft_rise)
        |=> mask[LIC_PHY])
        else $error("mask set ignored");
    a_mclr_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (mclr_wr && req.wdata[LIC_PHY]) |=> !mask[LIC_PHY])
        else $error("mask clear ignored");
    a_auto_copy: assert property (@(posedge clock) disable iff (!rst_n)
        (auto_go && auto_mask[LIC_RXLOW]) |=> !mask[LIC_RXLOW])
        else $error("auto mask not applied");
    a_auto_skip: assert property (@(posedge clock) disable iff (!rst_n)
        (cause_access && !cfg[LIC_CFG_NSQ] && !line && !soft_rise) |=> mask == $past(mask))
        else $error("auto mask applied without a live line");
    a_mask_keep30: assert property (@(posedge clock) disable iff (!rst_n)
        (soft_rise && next_mask[LIC_DRST]) |=> mask[LIC_DRST])
        else $error("mask bit 30 lost on soft reset");
    c_irq: cover property (@(posedge clock) disable iff (!rst_n) $rose(irq_line));
    c_cor: cover property (@(posedge clock) disable iff (!rst_n) cause_rd && line);
    c_auto: cover property (@(posedge clock) disable iff (!rst_n) auto_go);
    c_pin: cover property (@(posedge clock) disable iff (!rst_n) |hw_set_pin);
    c_soft: cover property (@(posedge clock) disable iff (!rst_n) soft_rise);

endmodule
`default_nettype wire

// ---- lic_host.sv ----
// Host side model: counts interrupt assertions seen on the line.
// Assumes the line is a level in the block's clock domain.
`timescale 1ns/1ps
`default_nettype none
module lic_host (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Interrupt line
    input wire logic irq_line,
    output logic [7:0] irq_seen
);
    logic irq_q;
    // Edge count only; a level held high is one interrupt
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_q <= 1'h0;
            irq_seen <= 8'h00;
        end else begin
            irq_q <= irq_line;
            if (irq_line && !irq_q) begin
                irq_seen <= irq_seen + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- lic_top_bench.sv ----
// Self-checking bench for the legacy interrupt cause and mask block.
// Assumes lic_pkg, lic_top and lic_host are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module lic_top_bench;
    import lic_pkg::*;
    logic clock, resetn, device_soft_reset, reg_wr, reg_rd, irq_line, summary;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val, missed;
    lic_events_t events;
    logic [4:0] bus_exception_enable;
    logic [3:0] pin_in, pin_detect_enable;
    logic [7:0] irq_seen, seen0;
    int n_errors = 0;
    int checks_done = 0;
    int cause_of [16] = '{0, 7, 2, 4, 6, 10, 19, 22, 24, 24, 24, 24, 24, 25, 26, 29};

    lic_top i_dut (.clock(clock), .resetn(resetn), .device_soft_reset(device_soft_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .events(events), .bus_exception_enable(bus_exception_enable),
        .pin_in(pin_in), .pin_detect_enable(pin_detect_enable), .irq_line(irq_line),
        .extended_summary_other_bit(summary), .missed_packet_counter(missed));
    lic_host i_host (.clock(clock), .resetn(resetn), .irq_line(irq_line),
        .irq_seen(irq_seen));

    task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask
    task automatic reg_read(input logic [15:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic check_word(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_flag(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic read_check(input string what, input logic [15:0] a,
        input logic [31:0] exp);
        reg_read(a);
        check_word(what, exp, rd_val);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    // Whole sequence takes well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        print_verdict();
    end
    initial begin
        resetn = 1'h0;
        device_soft_reset = 1'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 16'h0000;
        reg_wdata = 32'h00000000;
        events = lic_events_t'(16'h0000);
        bus_exception_enable = 5'h1F;
        pin_in = 4'h0;
        pin_detect_enable = 4'h0;
        repeat (5) @(posedge clock);
        resetn <= 1'h1;
        repeat (3) @(posedge clock);
        // Link change stays masked through setup
        read_check("mask_reset", LIC_MASK_OFF, 32'h00000000);
        read_check("cause_reset", LIC_CAUSE_OFF, 32'h00000000);
        $display("test reset done");
        for (int k = 0; k < 16; k++) begin
            @(posedge clock);
            events <= lic_events_t'(16'h8000 >> k);
            @(posedge clock);
            events <= lic_events_t'(16'h0000);
            repeat (10) @(posedge clock);
            read_check("event_cause", LIC_CAUSE_OFF, 32'h1 << cause_of[k]);
            read_check("read_clear", LIC_CAUSE_OFF, 32'h00000000);
        end
        check_word("missed_count", 32'h00000001, missed);
        $display("test events done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            pin_detect_enable <= 4'h1 << k;
            pin_in <= 4'hF;
            repeat (6) @(posedge clock);
            pin_in <= 4'h0;
            repeat (6) @(posedge clock);
            read_check("pin_cause", LIC_CAUSE_OFF, 32'h800 << k);
        end
        $display("test pins done");
        seen0 = irq_seen;
        reg_write(LIC_MASK_OFF, 32'h00000010);
        reg_write(LIC_MASK_OFF, 32'h00000000);
        read_check("mask_set", LIC_MASK_OFF, 32'h00000010);
        reg_write(LIC_SET_OFF, 32'h00000011);
        settle(2);
        check_flag("irq_line", 1'h1, irq_line);
        check_flag("summary_set", 1'h1, summary);
        check_word("host_irqs", 32'(seen0 + 8'h01), 32'(irq_seen));
        reg_write(LIC_AUTO_OFF, 32'h00000010);
        read_check("cause_line", LIC_CAUSE_OFF, 32'h80000011);
        settle(2);
        check_flag("summary_clear", 1'h0, summary);
        check_flag("irq_clear", 1'h0, irq_line);
        read_check("auto_masked", LIC_MASK_OFF, 32'h00000000);
        reg_write(LIC_AUTO_OFF, 32'h00000000);
        reg_write(LIC_MASK_OFF, 32'h00000404);
        reg_write(LIC_MCLR_OFF, 32'h00000004);
        read_check("mclr_read", LIC_MCLR_OFF, 32'h00000400);
        reg_write(LIC_MCLR_OFF, 32'h00000400);
        // No live line: the qualified copy must not happen
        reg_write(LIC_AUTO_OFF, 32'h00000010);
        reg_write(LIC_MASK_OFF, 32'h00000010);
        read_check("cause_idle", LIC_CAUSE_OFF, 32'h00000000);
        read_check("auto_skip", LIC_MASK_OFF, 32'h00000010);
        reg_write(LIC_CFG_OFF, 32'h00000002);
        read_check("cause_nsq", LIC_CAUSE_OFF, 32'h00000000);
        read_check("auto_nsq", LIC_MASK_OFF, 32'h00000000);
        reg_write(LIC_AUTO_OFF, 32'h00000000);
        $display("test mask done");
        reg_write(LIC_CFG_OFF, 32'h00000001);
        reg_write(LIC_SET_OFF, 32'h04000081);
        reg_write(LIC_CAUSE_OFF, 32'h00000000);
        repeat (20) @(posedge clock);
        read_check("cause_kept", LIC_CAUSE_OFF, 32'h04000081);
        reg_write(LIC_CAUSE_OFF, 32'h04000001);
        read_check("cause_w1c", LIC_CAUSE_OFF, 32'h00000080);
        reg_write(LIC_CAUSE_OFF, 32'h00000080);
        reg_write(LIC_CFG_OFF, 32'h00000000);
        read_check("unmapped", 16'h1600, 32'h00000000);
        $display("test clear done");
        reg_write(LIC_MASK_OFF, 32'h40000004);
        @(posedge clock);
        device_soft_reset <= 1'h1;
        repeat (2) @(posedge clock);
        device_soft_reset <= 1'h0;
        read_check("mask_kept", LIC_MASK_OFF, 32'h40000000);
        read_check("reset_cause", LIC_CAUSE_OFF, 32'hC0000000);
        reg_write(LIC_SET_OFF, 32'h40000000);
        settle(2);
        check_flag("reset_irq", 1'h1, irq_line);
        $display("test device reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
